//--- hdl/host_port_regs.vh
/*
 Constants for the host register port: address width, address range,
 data width, the internal access timing and reset levels.
 Assumes inclusion by a Verilog-2005 design file.
*/
`ifndef HOST_PORT_REGS_VH
`define HOST_PORT_REGS_VH

// ==========================================================
// Address and data layout
// ==========================================================
`define ADDR_WIDTH 13
`define ADDR_MSB 12
`define ADDR_LOW 13'h0000
`define ADDR_HIGH 13'h1FFF
`define DATA_WIDTH 8
`define DATA_MSB 7

// ==========================================================
// Timing (cycles of clk, the port's internal clock; host pins are asynchronous)
// ==========================================================
`define STORE_WAIT_CYCLES 2'h1
`define READ_WAIT_CYCLES 2'h1

// ==========================================================
// Reset values
// ==========================================================
`define RESET_DATA 8'h00
`define RESET_STATE 3'h0

`endif

//--- hdl/host_register_port.v
/*
 Host register port of the cell-delineation PHY: a byte-wide
 bidirectional data bus, a 13-bit register address, an open-drain
 transfer-done output and an open-drain interrupt request.
 Assumes: register storage sits outside this module behind a simple
 one-cycle store/fetch port; host pins are asynchronous and are
 synchronised here; interrupt causes arrive as a level from logic on clk.
*/
`timescale 1ns/10ps
`include "host_port_regs.vh"
module host_register_port (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Host control pins
   input wire host_select_n,
   input wire bus_style_select,
   input wire host_direction,
   input wire host_address_strobe_n,
   input wire host_read_strobe_n,
   input wire host_write_strobe_n,
   input wire [`ADDR_MSB:0] host_register_address,
   // Host data bus, split into three signals
   input wire [`DATA_MSB:0] host_data_bus_in,
   output reg [`DATA_MSB:0] host_data_bus_out,
   output reg host_data_bus_oe,
   // Transfer done, open drain: only the enable moves
   output reg host_transfer_done_out,
   output reg host_transfer_done_oe,
   // Interrupt request, open drain, active low
   output reg host_irq_n_out,
   output reg host_irq_n_oe,
   // Register storage port
   output reg [`ADDR_MSB:0] reg_address,
   output reg [`DATA_MSB:0] reg_write_data,
   output reg reg_write,
   output reg reg_read,
   input wire [`DATA_MSB:0] reg_read_data,
   // Internal interrupt cause, high while service is needed
   input wire irq_pending
);

   // ==========================================================
   // Access sequencer states
   // ==========================================================
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_STORE = 3'h1;
   localparam [2:0] ST_FETCH = 3'h2;
   localparam [2:0] ST_DONE_WR = 3'h3;
   localparam [2:0] ST_DONE_RD = 3'h4;

   wire [`ADDR_MSB:0] s_addr;
   wire [`DATA_MSB:0] s_data;
   wire [5:0] s_ctl;
   wire s_sel_n;
   wire s_style;
   wire s_dir;
   wire s_as_n;
   wire s_rd_n;
   wire s_wr_n;
   reg [2:0] state;
   reg [2:0] next_state;
   reg [1:0] wait_count;
   reg want_write;
   reg want_read;
   reg access_active;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   // Strobes reset to their inactive (high) level
   pin_sync #(.WIDTH(6), .INIT(6'h3F)) u_ctl_sync (
      .clk(clk),
      .reset(reset),
      .pin({host_select_n, bus_style_select, host_direction,
            host_address_strobe_n, host_read_strobe_n, host_write_strobe_n}),
      .synced(s_ctl)
   );

   pin_sync #(.WIDTH(`ADDR_WIDTH + `DATA_WIDTH)) u_bus_sync (
      .clk(clk),
      .reset(reset),
      .pin({host_register_address, host_data_bus_in}),
      .synced({s_addr, s_data})
   );

   assign s_sel_n = s_ctl[5];
   assign s_style = s_ctl[4];
   assign s_dir = s_ctl[3];
   assign s_as_n = s_ctl[2];
   assign s_rd_n = s_ctl[1];
   assign s_wr_n = s_ctl[0];

   // ==========================================================
   // Strobe decode by bus style
   // ==========================================================
   // Both SRAM strobes low at once is not a legal access; ignore it
   always @* begin
      want_write = 1'b0;
      want_read = 1'b0;
      if (!s_sel_n) begin
         if (s_style) begin
            want_write = !s_as_n && s_dir;
            want_read = !s_as_n && !s_dir;
         end else begin
            want_write = !s_wr_n && s_rd_n;
            want_read = !s_rd_n && s_wr_n;
         end
      end
      access_active = want_write || want_read;
   end

   // ==========================================================
   // Next state
   // ==========================================================
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (want_write) begin
               next_state = ST_STORE;
            end else if (want_read) begin
               next_state = ST_FETCH;
            end
         end
         ST_STORE: begin
            if (s_sel_n) begin
               next_state = ST_IDLE;
            end else if (wait_count == `STORE_WAIT_CYCLES) begin
               next_state = ST_DONE_WR;
            end
         end
         ST_FETCH: begin
            if (s_sel_n) begin
               next_state = ST_IDLE;
            end else if (wait_count == `READ_WAIT_CYCLES) begin
               next_state = ST_DONE_RD;
            end
         end
         ST_DONE_WR, ST_DONE_RD: begin
            // Hold done until the host ends the strobe, so each
            // access gets its own fresh done
            if (!access_active) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Sequencer and register port
   // ==========================================================
   always @(posedge clk) begin
      if (reset) begin
         state <= `RESET_STATE;
         wait_count <= 2'h0;
         reg_address <= `ADDR_LOW;
         reg_write_data <= `RESET_DATA;
         reg_write <= 1'b0;
         reg_read <= 1'b0;
      end else begin
         state <= next_state;
         reg_write <= 1'b0;
         reg_read <= 1'b0;
         if (state == ST_IDLE && access_active) begin
            // Full 13-bit address covers 0000-1FFF with no holes
            reg_address <= s_addr;
            reg_write_data <= s_data;
            reg_write <= want_write;
            reg_read <= want_read;
            wait_count <= 2'h0;
         end else if (state == ST_STORE || state == ST_FETCH) begin
            wait_count <= wait_count + 2'h1;
         end
      end
   end

   // ==========================================================
   // Pin drivers, all registered
   // ==========================================================
   always @(posedge clk) begin
      if (reset) begin
         host_data_bus_out <= `RESET_DATA;
         host_data_bus_oe <= 1'b0;
         host_transfer_done_out <= 1'b0;
         host_transfer_done_oe <= 1'b0;
         host_irq_n_out <= 1'b0;
         host_irq_n_oe <= 1'b0;
      end else begin
         // Read data is captured as the fetch completes and held
         if (state == ST_FETCH && next_state == ST_DONE_RD) begin
            host_data_bus_out <= reg_read_data;
         end
         // Drive only while returning read data and selected
         host_data_bus_oe <= !s_sel_n && (next_state == ST_DONE_RD);
         // Done goes high by release; pull-up makes the level
         host_transfer_done_out <= 1'b0;
         host_transfer_done_oe <= !s_sel_n &&
            !(next_state == ST_DONE_WR || next_state == ST_DONE_RD);
         // Interrupt ignores select; follows the cause level
         host_irq_n_out <= 1'b0;
         host_irq_n_oe <= irq_pending;
      end
   end

endmodule

//--- hdl/pin_sync.v
/*
 Two-stage synchroniser for a bundle of asynchronous pin inputs.
 Assumes one clock; the first stage is read only by the second.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Pin side
   input wire [WIDTH-1:0] pin,
   // Synchronised side
   output reg [WIDTH-1:0] synced
);

   reg [WIDTH-1:0] stage1;

   // ==========================================================
   // Two flip-flop chain
   // ==========================================================
   always @(posedge clk) begin
      if (reset) begin
         stage1 <= INIT;
         synced <= INIT;
      end else begin
         stage1 <= pin;
         synced <= stage1;
      end
   end

endmodule

//--- verification/host_port_checker_asserts.sv
/*
 Checker for the host register port, bound to its top module.
 Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/10ps
module host_port_checker (
   // Clock and reset
   input wire clk,
   input wire reset,
   // Watched ports
   input wire host_select_n,
   input wire [12:0] host_register_address,
   input wire [7:0] host_data_bus_in,
   input wire host_data_bus_oe,
   input wire host_transfer_done_out,
   input wire host_transfer_done_oe,
   input wire host_irq_n_out,
   input wire host_irq_n_oe,
   input wire [12:0] reg_address,
   input wire [7:0] reg_write_data,
   input wire reg_write,
   input wire reg_read,
   input wire irq_pending
);
   // =====
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   property p_od; !host_transfer_done_out && !host_irq_n_out; endproperty
   a_od: assert property (p_od) else $error("open drain driven high");
   property p_irq; !$past(reset) |-> host_irq_n_oe == $past(irq_pending); endproperty
   a_irq: assert property (p_irq) else $error("irq not following cause");
   property p_bus; host_data_bus_oe |-> !host_transfer_done_oe; endproperty
   a_bus: assert property (p_bus) else $error("bus driven outside read");
   property p_wr; $rose(reg_write) |-> ##2 !host_transfer_done_oe; endproperty
   a_wr: assert property (p_wr) else $error("write done late");
   property p_rd; $rose(reg_read) |-> ##2 host_data_bus_oe; endproperty
   a_rd: assert property (p_rd) else $error("read data late");
   property p_one; reg_write |-> !reg_read; endproperty
   a_one: assert property (p_one) else $error("store and fetch together");
   property p_desel; host_select_n [*4] |-> !host_data_bus_oe && !host_transfer_done_oe;
   endproperty
   a_desel: assert property (p_desel) else $error("deselected port active");
   property p_fresh; $fell(host_transfer_done_oe) && !host_select_n
      |-> $past(reg_write, 2) || $past(reg_read, 2); endproperty
   a_fresh: assert property (p_fresh) else $error("done without access");
   property p_cap; reg_write |-> reg_address == $past(host_register_address)
      && reg_write_data == $past(host_data_bus_in); endproperty
   a_cap: assert property (p_cap) else $error("wrong address or data");
endmodule
bind host_register_port host_port_checker host_port_checker_i (.clk, .reset,
   .host_select_n, .host_register_address, .host_data_bus_in, .host_data_bus_oe,
   .host_transfer_done_out, .host_transfer_done_oe, .host_irq_n_out, .host_irq_n_oe,
   .reg_address, .reg_write_data, .reg_write, .reg_read, .irq_pending);

//--- verification/reg_store_model.sv
/*
 Register storage behind the port: stores on a pulse, answers a fetch.
 Assumes read data is taken the cycle after the fetch pulse.
*/
`timescale 1ns/10ps
module reg_store_model (
   // Clock
   input wire clk,
   // Storage port
   input wire [12:0] reg_address,
   input wire [7:0] reg_write_data,
   input wire reg_write,
   input wire reg_read,
   output logic [7:0] reg_read_data
);
   logic [7:0] mem [0:8191];
   // Full 13-bit space; stale data is inverted every cycle, so it matches the read value again on alternate cycles
   always @(posedge clk) begin
      if (reg_write) mem[reg_address] <= reg_write_data;
      reg_read_data <= reg_read ? mem[reg_address] : ~reg_read_data;
   end
endmodule

//--- verification/tb.sv
/*
 Self-checking bench for the host register port acting as the host.
 Assumes the storage model behind the port and a 40 MHz clock.
*/
`timescale 1ns/10ps
module tb;
   logic clk, reset, sel_n, style, dir, as_n, rd_n, wr_n, irqp, dbo, doe, ioe, rw, rr;
   logic [12:0] addr, ra;
   logic [7:0] hd, dout, wd, rdat;
   logic [7:0] em [int];
   int unsigned seed = 12645;
   int n_mismatch = 0, tests_run = 0, i;
   logic [31:0] r;
   // Wire level of the shared data bus
   wire [7:0] bus = dbo ? dout : hd;
   host_register_port host_register_port_i (.clk(clk), .reset(reset), .host_select_n(sel_n),
      .bus_style_select(style), .host_direction(dir), .host_address_strobe_n(as_n),
      .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_register_address(addr),
      .host_data_bus_in(bus), .host_data_bus_out(dout), .host_data_bus_oe(dbo),
      .host_transfer_done_out(), .host_transfer_done_oe(doe), .host_irq_n_out(),
      .host_irq_n_oe(ioe), .reg_address(ra), .reg_write_data(wd), .reg_write(rw),
      .reg_read(rr), .reg_read_data(rdat), .irq_pending(irqp));
   reg_store_model reg_store_model_i (.clk(clk), .reg_address(ra), .reg_write_data(wd),
      .reg_write(rw), .reg_read(rr), .reg_read_data(rdat));
   // =====
   // Clock and helpers
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task wrap_up();
      $display("mismatches %0d of %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // Bounded wait on the done line pull enable
   task wt(input logic v);
      int k;
      for (k = 0; k < 40 && doe !== v; k++) tick(1);
      if (doe !== v) begin
         chk(doe, v);
         wrap_up();
      end
   endtask
   // One byte access; host holds everything until done is released
   task acc(input logic s, input logic w, input logic [12:0] a, input logic [7:0] d);
      sel_n = 0;
      wt(1);
      style = s;
      dir = w;
      addr = a;
      hd = w ? d : ~hd;
      as_n = ~s;
      rd_n = s | w;
      wr_n = s | ~w;
      wt(0);
      if (w) em[a] = d;
      chk(dbo, !w);
      if (!w) chk(dout, em[a]);
      as_n = 1;
      rd_n = 1;
      wr_n = 1;
      wt(1);
      tick(3);
   endtask
   // =====
   // Main sequence
   initial begin
      reset = 1; sel_n = 1; style = 1; dir = 0; as_n = 1; rd_n = 1; wr_n = 1;
      addr = 0; hd = 0; irqp = 0;
      tick(16);
      reset = 0;
      tick(3);
      acc(1, 1, 13'h0000, 8'hA5);
      acc(0, 1, 13'h1FFF, 8'h5A);
      acc(0, 0, 13'h0000, 8'h00);
      acc(1, 0, 13'h1FFF, 8'h00);
      $display("corner addresses done");
      for (i = 0; i < 12; i++) begin
         r = xs();
         acc(r[0], 1, r[20:8], r[31:24]);
         acc(~r[0], 0, r[20:8], 8'h00);
      end
      $display("random accesses done");
      style = 0;
      rd_n = 0;
      wr_n = 0;
      tick(10);
      chk(doe, 1);
      chk(dbo, 0);
      rd_n = 1;
      wr_n = 1;
      $display("double strobe done");
      sel_n = 1;
      style = 1;
      as_n = 0;
      irqp = 1;
      tick(8);
      chk({dbo, doe}, 8'h00);
      chk(ioe, 1);
      irqp = 0;
      tick(2);
      chk(ioe, 0);
      as_n = 1;
      $display("deselect and irq done");
      wrap_up();
   end
endmodule
